// ==== sdreg_bank.sv ====
// Summary of operation
// - Holds conditions 32, identity 128, specific 128, address 16, feature 64, status 512.
// - No driver stage register; its presence flag in specific data reads zero.
// - Conditions bits 15..23 flag supply windows; other low bits reserved.
// - Conditions bit 31 reads low until internal power-up completes.
// - Capacity flag bit 30 meaningful only while bit 31 set.
// - Identity layout: maker, application, name, revision, serial, date, CRC, one.
// - Identity value is fixed by module parameters.
// - Specific data structure version 01b; reserved zero; bit 0 one.
// - Access time code 0Eh, clock access term 00h.
// - Transfer rate code 32h or 5Ah per speed setting.
// - Read and write block length codes are 9.
// - Partial blocks and misalignment fields read zero.
// - Only copy, permanent, temporary protect and CRC fields are writable.
// - Copy and permanent protect written once; temporary protect freely.
// - Relative address writable, resets to zero.
// - Select by relative address; zero address sends all to stand-by.
`timescale 1ns/1ps
module sdreg_bank
  import sdreg_pkg::*;
#(
  parameter logic [7:0]         CID_MAKER     = 8'h5a,       // Arbitrary value
  parameter logic [15:0]        CID_APP       = 16'h4142,    // Arbitrary value
  parameter logic [39:0]        CID_NAME      = 40'h5245474b31,
  parameter logic [7:0]         CID_REV       = 8'h10,
  parameter logic [31:0]        CID_SERIAL    = 32'h00000001,
  parameter logic [11:0]        CID_DATE      = 12'h001,
  parameter logic [11:0]        CSD_CCC       = 12'h5b5,
  parameter logic [21:0]        CSD_C_SIZE    = 22'h000fff,
  parameter logic [8:0]         OCR_WINDOWS   = 9'h1ff,
  parameter logic               CAPACITY_HIGH = 1'b1,
  parameter logic [SCR_W-1:0]   SCR_VALUE     = 64'h0235000000000000,
  parameter logic [SSTAT_W-1:0] SSTAT_VALUE   = '0
)(
  input  wire logic                 clk_in,
  input  wire logic                 rst_in,
  input  wire logic                 power_done_in,
  input  wire logic                 speed_high_in,
  input  wire sdreg_rd_req_t        rd_req_in,
  output logic      [WORD_W-1:0]    rd_data_out,
  output logic                      rd_valid_out,
  output logic                      rd_err_out,
  input  wire logic                 csd_wr_in,
  input  wire logic [CSD_W-1:0]     csd_wr_data_in,
  output logic                      csd_wr_done_out,
  output logic                      csd_wr_err_out,
  input  wire logic                 rca_wr_in,
  input  wire logic [RCA_W-1:0]     rca_wr_data_in,
  output logic      [RCA_W-1:0]     rca_out,
  input  wire logic                 sel_cmd_in,
  input  wire logic [RCA_W-1:0]     sel_addr_in,
  output logic                      card_selected_out
);

  ////////////////////////////////////////////////////////////////////////////
  // Functions

  function automatic logic [CSD_W-1:0] csd_image(
    input logic             spd_hi,
    input logic             copy,
    input logic             perm,
    input logic             tmp,
    input logic [CRC_W-1:0] crc
  );
    csd_image = {CSD_STRUCT_VER, 6'h00, CSD_ACCESS_TIME_CODE, CSD_ACCESS_CLOCK_TERM,
                 (spd_hi ? CSD_SPEED_HI : CSD_SPEED_STD),
                 CSD_CCC, CSD_BL_LEN,
                 1'b0, 1'b0, 1'b0,
                 CSD_DRIVER_STAGE_PRESENT,
                 6'h00, CSD_C_SIZE, 1'b0, CSD_ERASE_BLK, CSD_SECTOR,
                 7'h00, 1'b0, 2'h0, CSD_R2W, CSD_BL_LEN,
                 1'b0,
                 5'h00, 1'b0, copy, perm, tmp, 2'h0, 2'h0, crc, 1'b1};
  endfunction

  function automatic logic [4:0] sel_words(input sdreg_sel_t sel);
    case (sel)
      SEL_OCR:   sel_words = WORDS_OCR;
      SEL_CID:   sel_words = WORDS_CID;
      SEL_CSD:   sel_words = WORDS_CSD;
      SEL_RCA:   sel_words = WORDS_RCA;
      SEL_SCR:   sel_words = WORDS_SCR;
      SEL_SSTAT: sel_words = WORDS_SSTAT;
      default:   sel_words = WORDS_NONE;
    endcase
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // State

  logic                 copy_q;
  logic                 perm_q;
  logic                 tmp_q;
  logic                 copy_prog_q;
  logic                 perm_prog_q;
  logic [CRC_W-1:0]     crc_q;
  logic                 crc_set_q;
  logic [RCA_W-1:0]     rca_q;
  sdreg_state_t         state_q;
  logic [WORD_W-1:0]    rd_data_q;
  logic                 rd_valid_q;
  logic                 rd_err_q;
  logic                 wr_done_q;
  logic                 wr_err_q;

  logic [CSD_W-1:0]     csd_body;
  logic [CSD_W-1:0]     csd_view;
  logic [CID_W-1:0]     cid_view;
  logic [OCR_W-1:0]     ocr_view;
  logic [CRC_W-1:0]     cid_crc;
  logic [CRC_W-1:0]     csd_crc;
  logic [SSTAT_W-1:0]   rd_view;
  logic                 wr_bad;

  ////////////////////////////////////////////////////////////////////////////
  // Register images

  always_comb begin
    ocr_view = '0;
    ocr_view[OCR_WIN_HI:OCR_WIN_LO] = OCR_WINDOWS;
    ocr_view[OCR_BUSY_BIT] = power_done_in;
    ocr_view[OCR_CCS_BIT]  = power_done_in & CAPACITY_HIGH;
  end

  assign cid_view = {CID_MAKER, CID_APP, CID_NAME, CID_REV,
                     CID_SERIAL, 4'h0, CID_DATE, cid_crc, 1'b1};

  sdreg_crc7 u_cid_crc (
    .data_in ({CID_MAKER, CID_APP, CID_NAME, CID_REV,
               CID_SERIAL, 4'h0, CID_DATE}),
    .crc_out (cid_crc)
  );

  assign csd_body = csd_image(speed_high_in, copy_q, perm_q, tmp_q, '0);

  sdreg_crc7 u_csd_crc (
    .data_in (csd_body[CSD_W-1:CSD_W-CRC_SPAN]),
    .crc_out (csd_crc)
  );

  assign csd_view = csd_image(speed_high_in, copy_q, perm_q, tmp_q,
                              crc_set_q ? crc_q : csd_crc);

  ////////////////////////////////////////////////////////////////////////////
  // Read port

  always_comb begin
    rd_view = '0;
    case (rd_req_in.sel)
      SEL_OCR:   rd_view[OCR_W-1:0] = ocr_view;
      SEL_CID:   rd_view[CID_W-1:0] = cid_view;
      SEL_CSD:   rd_view[CSD_W-1:0] = csd_view;
      SEL_RCA:   rd_view[RCA_W-1:0] = rca_q;
      SEL_SCR:   rd_view[SCR_W-1:0] = SCR_VALUE;
      SEL_SSTAT: rd_view = SSTAT_VALUE;
      default:   rd_view = '0;
    endcase
  end

  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      rd_data_q  <= '0;
      rd_valid_q <= 1'b0;
      rd_err_q   <= 1'b0;
    end else begin
      rd_valid_q <= rd_req_in.valid;
      rd_err_q   <= 1'b0;
      if (rd_req_in.valid) begin
        if ({1'b0, rd_req_in.word} < sel_words(rd_req_in.sel)) begin
          rd_data_q <= rd_view[rd_req_in.word*WORD_W +: WORD_W];
        end else begin
          rd_data_q <= '0;
          rd_err_q  <= 1'b1;
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Specific-data programming

  always_comb begin
    wr_bad = |((csd_wr_data_in ^ csd_view) & ~CSD_WR_MASK);
    if (copy_prog_q && (csd_wr_data_in[CSD_COPY_BIT] != copy_q)) begin
      wr_bad = 1'b1;
    end
    if (perm_prog_q && (csd_wr_data_in[CSD_PERM_BIT] != perm_q)) begin
      wr_bad = 1'b1;
    end
  end

  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      copy_q      <= 1'b0;
      perm_q      <= 1'b0;
      tmp_q       <= 1'b0;
      copy_prog_q <= 1'b0;
      perm_prog_q <= 1'b0;
      crc_q       <= '0;
      crc_set_q   <= 1'b0;
      wr_done_q   <= 1'b0;
      wr_err_q    <= 1'b0;
    end else begin
      wr_done_q <= 1'b0;
      wr_err_q  <= 1'b0;
      if (csd_wr_in) begin
        if (wr_bad) begin
          wr_err_q <= 1'b1;
        end else begin
          wr_done_q   <= 1'b1;
          copy_q      <= csd_wr_data_in[CSD_COPY_BIT];
          perm_q      <= csd_wr_data_in[CSD_PERM_BIT];
          tmp_q       <= csd_wr_data_in[CSD_TMP_BIT];
          crc_q       <= csd_wr_data_in[CSD_CRC_HI:CSD_CRC_LO];
          crc_set_q   <= 1'b1;
          copy_prog_q <= 1'b1;
          perm_prog_q <= 1'b1;
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Relative address and selection

  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      rca_q <= RCA_RESET;
    end else if (rca_wr_in) begin
      rca_q <= rca_wr_data_in;
    end
  end

  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      state_q <= ST_STBY;
    end else if (sel_cmd_in) begin
      case (state_q)
        ST_STBY: begin
          if ((sel_addr_in == rca_q) && (sel_addr_in != RCA_RESET)) begin
            state_q <= ST_TRAN;
          end
        end
        ST_TRAN: begin
          if (sel_addr_in != rca_q || sel_addr_in == RCA_RESET) begin
            state_q <= ST_STBY;
          end
        end
        default: state_q <= ST_STBY;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Outputs

  assign rd_data_out       = rd_data_q;
  assign rd_valid_out      = rd_valid_q;
  assign rd_err_out        = rd_err_q;
  assign csd_wr_done_out   = wr_done_q;
  assign csd_wr_err_out    = wr_err_q;
  assign rca_out           = rca_q;
  assign card_selected_out = (state_q == ST_TRAN);

  ////////////////////////////////////////////////////////////////////////////
  // Assertions

  default clocking cb @(posedge clk_in); endclocking
  default disable iff (rst_in);

  sequence s_rd(sdreg_sel_t s, logic [WIDX_W-1:0] w);
    rd_req_in.valid && rd_req_in.sel == s && rd_req_in.word == w;
  endsequence

  a_ocr_busy_low: assert property (s_rd(SEL_OCR, 4'h0) ##0 !power_done_in
    |=> rd_valid_out && !rd_data_out[OCR_BUSY_BIT])
    else $error("busy flag high before power-up done");

  a_ccs_masked: assert property (s_rd(SEL_OCR, 4'h0)
    |=> rd_data_out[OCR_CCS_BIT] == ($past(power_done_in) & CAPACITY_HIGH))
    else $error("capacity flag not gated by power-up");

  a_ocr_window: assert property (s_rd(SEL_OCR, 4'h0)
    |=> rd_data_out[OCR_WIN_HI:OCR_WIN_LO] == OCR_WINDOWS
        && rd_data_out[OCR_RSV_HI:OCR_RSV_LO] == 6'h00
        && rd_data_out[OCR_WIN_LO-1:0] == 15'h0000)
    else $error("voltage window or reserved bits wrong");

  a_dsr_absent: assert property (rd_req_in.valid && rd_req_in.sel == SEL_DSR
    |=> rd_err_out && rd_data_out == '0)
    else $error("driver stage register answered");

  a_csd_head: assert property (s_rd(SEL_CSD, 4'h3)
    |=> rd_data_out[31:30] == CSD_STRUCT_VER && rd_data_out[29:24] == 6'h00
        && rd_data_out[23:16] == CSD_ACCESS_TIME_CODE && rd_data_out[15:8] == CSD_ACCESS_CLOCK_TERM
        && rd_data_out[7:0] == ($past(speed_high_in) ? CSD_SPEED_HI : CSD_SPEED_STD))
    else $error("specific data head fields wrong");

  a_csd_blocks: assert property (s_rd(SEL_CSD, 4'h2)
    |=> rd_data_out[19:16] == CSD_BL_LEN && rd_data_out[15:12] == 4'h0)
    else $error("block length or partial fields wrong");

  a_cid_tail: assert property (s_rd(SEL_CID, 4'h0)
    |=> rd_data_out[0] && rd_data_out[CRC_W:1] == $past(cid_crc)
        && rd_data_out[23:20] == 4'h0)
    else $error("identity tail wrong");

  a_otp_once: assert property (csd_wr_in && copy_prog_q
      && csd_wr_data_in[CSD_COPY_BIT] != copy_q
    |=> csd_wr_err_out && !csd_wr_done_out && $stable(copy_q) && $stable(tmp_q))
    else $error("one-time flag rewritten");

  a_ro_reject: assert property (csd_wr_in
      && |((csd_wr_data_in ^ csd_view) & ~CSD_WR_MASK)
    |=> csd_wr_err_out ##0 $stable(crc_q) && $stable(perm_q))
    else $error("read-only field write accepted");

  a_rca_write: assert property (rca_wr_in |=> rca_out == $past(rca_wr_data_in))
    else $error("relative address not stored");

  a_deselect_zero: assert property (sel_cmd_in && sel_addr_in == RCA_RESET
    |=> !card_selected_out)
    else $error("zero address did not deselect");

  a_rd_answer: assert property (rd_req_in.valid |=> rd_valid_out)
    else $error("read request not answered");

  a_rd_idle: assert property (!rd_req_in.valid |=> !rd_valid_out && !rd_err_out)
    else $error("read answer without request");

  sequence s_prog_ok;
    csd_wr_in && !wr_bad ##1 $stable(speed_high_in);
  endsequence

  a_prog_lands: assert property (s_prog_ok
    |-> csd_wr_done_out && !csd_wr_err_out && csd_view == $past(csd_wr_data_in))
    else $error("accepted program not stored");

  a_sel_match: assert property (sel_cmd_in && sel_addr_in == rca_q
      && rca_q != RCA_RESET && !card_selected_out
    |=> card_selected_out)
    else $error("matching address did not select");

endmodule

// ==== sdreg_crc7.sv ====
`timescale 1ns/1ps
module sdreg_crc7
  import sdreg_pkg::*;
(
  input  wire logic [CRC_SPAN-1:0] data_in,
  output logic      [CRC_W-1:0]    crc_out
);

  logic             fb;
  logic [CRC_W-1:0] c;

  // Serial x^7 + x^3 + 1, MSB first
  always_comb begin
    c  = '0;
    fb = 1'b0;
    for (int i = CRC_SPAN - 1; i >= 0; i--) begin
      fb = data_in[i] ^ c[CRC_W-1];
      c  = {c[CRC_W-2:0], 1'b0};
      if (fb) begin
        c = c ^ CRC_POLY;
      end
    end
    crc_out = c;
  end

endmodule

// ==== sdreg_host_model.sv ====
`timescale 1ns/1ps
module sdreg_host_model
  import sdreg_pkg::*;
(
  input  wire logic                clk_in,
  output sdreg_rd_req_t            rd_req_out,
  input  wire logic [WORD_W-1:0]   rd_data_in,
  input  wire logic                rd_valid_in,
  input  wire logic                rd_err_in,
  output logic                     csd_wr_out,
  output logic      [CSD_W-1:0]    csd_wr_data_out,
  input  wire logic                csd_wr_done_in,
  input  wire logic                csd_wr_err_in,
  output logic                     rca_wr_out,
  output logic      [RCA_W-1:0]    rca_wr_data_out,
  output logic                     sel_cmd_out,
  output logic      [RCA_W-1:0]    sel_addr_out
);
  // Idle power-up clocks before the first command
  localparam int PWR_CLKS = 74;
  initial begin
    rd_req_out      = '0;
    csd_wr_out      = 1'h0;
    csd_wr_data_out = '0;
    rca_wr_out      = 1'h0;
    rca_wr_data_out = '0;
    sel_cmd_out     = 1'h0;
    sel_addr_out    = '0;
  end
  ////////////////////////////////////////
  // Released qualifiers show the inverse of the last value
  task automatic read(input sdreg_sel_t s, input logic [WIDX_W-1:0] w,
                      output logic [WORD_W-1:0] d, output logic e, output logic v);
    @(posedge clk_in);
    #1 rd_req_out = '{valid: 1'h1, sel: s, word: w};
    @(posedge clk_in);
    #1 rd_req_out = '{valid: 1'h0, sel: sdreg_sel_t'(~s), word: ~w};
    d = rd_data_in;
    e = rd_err_in;
    v = rd_valid_in;
  endtask
  task automatic power_up();
    repeat (PWR_CLKS) @(posedge clk_in);
  endtask
  task automatic op_cond(input logic host_capacity_flag, output logic [WORD_W-1:0] d, output logic capacity_status_flag);
    logic e;
    logic v;
    read(SEL_OCR, 4'h0, d, e, v);
    capacity_status_flag = host_capacity_flag & d[OCR_BUSY_BIT] & d[OCR_CCS_BIT];
  endtask
  task automatic prog(input logic [CSD_W-1:0] img, output logic done, output logic err);
    @(posedge clk_in);
    #1 csd_wr_out = 1'h1;
    csd_wr_data_out = img;
    @(posedge clk_in);
    #1 csd_wr_out = 1'h0;
    csd_wr_data_out = ~img;
    done = csd_wr_done_in;
    err  = csd_wr_err_in;
  endtask
  task automatic rca_write(input logic [RCA_W-1:0] a);
    @(posedge clk_in);
    #1 rca_wr_out = 1'h1;
    rca_wr_data_out = a;
    @(posedge clk_in);
    #1 rca_wr_out = 1'h0;
    rca_wr_data_out = ~a;
  endtask
  task automatic select(input logic [RCA_W-1:0] a);
    @(posedge clk_in);
    #1 sel_cmd_out = 1'h1;
    sel_addr_out = a;
    @(posedge clk_in);
    #1 sel_cmd_out = 1'h0;
    sel_addr_out = ~a;
  endtask
endmodule

// ==== sdreg_pkg.sv ====
package sdreg_pkg;

  // Register widths
  localparam int OCR_W    = 32;
  localparam int CID_W    = 128;
  localparam int CSD_W    = 128;
  localparam int RCA_W    = 16;
  localparam int DSR_W    = 16;
  localparam int SCR_W    = 64;
  localparam int SSTAT_W  = 512;
  localparam int WORD_W   = 32;
  localparam int WIDX_W   = 4;
  localparam int CRC_W    = 7;
  localparam int CRC_SPAN = 120;

  // Register selector codes
  typedef enum logic [2:0] {
    SEL_OCR   = 3'h0,
    SEL_CID   = 3'h1,
    SEL_CSD   = 3'h2,
    SEL_RCA   = 3'h3,
    SEL_DSR   = 3'h4,
    SEL_SCR   = 3'h5,
    SEL_SSTAT = 3'h6
  } sdreg_sel_t;

  // Words per register on the read port
  localparam logic [4:0] WORDS_OCR   = 5'h01;
  localparam logic [4:0] WORDS_CID   = 5'h04;
  localparam logic [4:0] WORDS_CSD   = 5'h04;
  localparam logic [4:0] WORDS_RCA   = 5'h01;
  localparam logic [4:0] WORDS_SCR   = 5'h02;
  localparam logic [4:0] WORDS_SSTAT = 5'h10;
  localparam logic [4:0] WORDS_NONE  = 5'h00;

  // Card state, one-hot
  typedef enum logic [1:0] {
    ST_STBY = 2'b01,
    ST_TRAN = 2'b10
  } sdreg_state_t;

  // Read request carrier
  typedef struct packed {
    logic              valid;
    sdreg_sel_t        sel;
    logic [WIDX_W-1:0] word;
  } sdreg_rd_req_t;

  // Operating-conditions field positions
  localparam int OCR_BUSY_BIT = 31;
  localparam int OCR_CCS_BIT  = 30;
  localparam int OCR_WIN_LO   = 15;
  localparam int OCR_WIN_HI   = 23;
  localparam int OCR_RSV_LO   = 24;
  localparam int OCR_RSV_HI   = 29;

  // Card-specific-data fixed values
  localparam logic [1:0]  CSD_STRUCT_VER = 2'h1;
  localparam logic [7:0]  CSD_ACCESS_TIME_CODE       = 8'h0e;
  localparam logic [7:0]  CSD_ACCESS_CLOCK_TERM       = 8'h00;
  localparam logic [7:0]  CSD_SPEED_STD  = 8'h32;
  localparam logic [7:0]  CSD_SPEED_HI   = 8'h5a;
  localparam logic [3:0]  CSD_BL_LEN     = 4'h9;
  localparam logic        CSD_ERASE_BLK  = 1'b1;
  localparam logic [6:0]  CSD_SECTOR     = 7'h7f;
  localparam logic [2:0]  CSD_R2W        = 3'h2;
  localparam logic        CSD_DRIVER_STAGE_PRESENT    = 1'b0;

  // Card-specific-data field positions
  localparam int CSD_COPY_BIT = 14;
  localparam int CSD_PERM_BIT = 13;
  localparam int CSD_TMP_BIT  = 12;
  localparam int CSD_CRC_LO   = 1;
  localparam int CSD_CRC_HI   = 7;
  localparam logic [CSD_W-1:0] CSD_WR_MASK = 128'h70fe;

  // Reset value and CRC polynomial
  localparam logic [RCA_W-1:0] RCA_RESET = 16'h0000;
  localparam logic [CRC_W-1:0] CRC_POLY  = 7'h09;

endpackage

// ==== tb_top.sv ====
`timescale 1ns/1ps
module tb_top;
  import sdreg_pkg::*;
  localparam logic [7:0]         MAKER = 8'h3c;  // Arbitrary value
  localparam logic [15:0]        APP   = 16'h7a51; // Arbitrary value
  localparam logic [39:0]        NAME  = 40'h0102030405;
  localparam logic [31:0]        SERNO = 32'h0badcafe;
  localparam logic [11:0]        CCC   = 12'h5b5;
  localparam logic [21:0]        CSIZE = 22'h000123;
  localparam logic [63:0]        SCRV  = 64'h0123456789abcdef;
  localparam logic [SSTAT_W-1:0] STV   = {32'hfeed0f0f, 448'h0, 32'h13572468};
  logic clk_in, rst_in, power_done, speed_high, rd_valid, rd_err, csd_wr, done, err;
  logic rca_wr, sel_cmd, card_sel;
  logic [WORD_W-1:0] rd_data;
  logic [CSD_W-1:0]  csd_wr_data;
  logic [RCA_W-1:0]  rca_wr_data, rca_q, sel_addr;
  sdreg_rd_req_t     rd_req;
  int num_errors = 0;
  int checks = 0;
  sdreg_bank #(.CID_MAKER(MAKER), .CID_APP(APP), .CID_NAME(NAME), .CID_REV(8'h21),
    .CID_SERIAL(SERNO), .CID_DATE(12'h16a), .CSD_CCC(CCC), .CSD_C_SIZE(CSIZE),
    .OCR_WINDOWS(9'h1ff), .CAPACITY_HIGH(1'h1), .SCR_VALUE(SCRV), .SSTAT_VALUE(STV)) uut (
    .clk_in(clk_in), .rst_in(rst_in), .power_done_in(power_done),
    .speed_high_in(speed_high), .rd_req_in(rd_req), .rd_data_out(rd_data),
    .rd_valid_out(rd_valid), .rd_err_out(rd_err), .csd_wr_in(csd_wr),
    .csd_wr_data_in(csd_wr_data), .csd_wr_done_out(done), .csd_wr_err_out(err),
    .rca_wr_in(rca_wr), .rca_wr_data_in(rca_wr_data), .rca_out(rca_q),
    .sel_cmd_in(sel_cmd), .sel_addr_in(sel_addr), .card_selected_out(card_sel));
  sdreg_host_model host (
    .clk_in(clk_in), .rd_req_out(rd_req), .rd_data_in(rd_data), .rd_valid_in(rd_valid),
    .rd_err_in(rd_err), .csd_wr_out(csd_wr), .csd_wr_data_out(csd_wr_data),
    .csd_wr_done_in(done), .csd_wr_err_in(err), .rca_wr_out(rca_wr),
    .rca_wr_data_out(rca_wr_data), .sel_cmd_out(sel_cmd), .sel_addr_out(sel_addr));
  ////////////////////////////////////////
  initial begin
    clk_in = 1'h0;
    forever #20 clk_in = ~clk_in;
  end
  function automatic logic [6:0] crc7(input logic [119:0] m);
    logic [6:0] c;
    logic       fb;
    c = 7'h00;
    for (int i = 119; i >= 0; i--) begin
      fb = m[i] ^ c[6];
      c = {c[5:0], 1'h0} ^ (fb ? 7'h09 : 7'h00);
    end
    return c;
  endfunction
  function automatic logic [127:0] csd_exp(input logic spd, cp, pm, tp,
                                           input logic [6:0] crc, input logic own_crc);
    logic [127:0] b;
    b = {2'h1, 6'h0, 8'h0e, 8'h00, spd ? 8'h5a : 8'h32, CCC, 4'h9, 4'h0, 6'h0, CSIZE,
         1'h0, 1'h1, 7'h7f, 7'h0, 1'h0, 2'h0, 3'h2, 4'h9, 1'h0, 5'h0, 1'h0, cp, pm, tp,
         4'h0, 7'h0, 1'h1};
    b[7:1] = own_crc ? crc : crc7(b[127:8]);
    return b;
  endfunction
  task automatic chk(input string n, input logic [127:0] exp, input logic [127:0] got);
    checks++;
    if (got !== exp) begin
      num_errors++;
      $display("wrong value %s expected %h seen %h", n, exp, got);
    end
  endtask
  task automatic rdw(input sdreg_sel_t s, input logic [3:0] w,
                     output logic [31:0] d, output logic e);
    logic v;
    host.read(s, w, d, e, v);
    chk("rd_valid", 128'h1, v);
  endtask
  task automatic rd128(input sdreg_sel_t s, output logic [127:0] r);
    logic [31:0] d;
    logic        e;
    for (int w = 0; w < 4; w++) begin
      rdw(s, w[3:0], d, e);
      r[32*w +: 32] = d;
      chk("rd_err", 128'h0, e);
    end
  endtask
  ////////////////////////////////////////
  task automatic t_ocr();
    logic [31:0] d;
    logic        e;
    logic        c;
    chk("rca_out", 128'h0, rca_q);
    chk("card_selected", 128'h0, card_sel);
    rdw(SEL_OCR, 4'h0, d, e);
    chk("ocr_busy", {1'h0, 1'h0, 6'h0, 9'h1ff, 15'h0}, d);
    power_done = 1'h1;
    rdw(SEL_OCR, 4'h0, d, e);
    chk("ocr_ready", {1'h1, 1'h1, 6'h0, 9'h1ff, 15'h0}, d);
    host.op_cond(1'h1, d, c);
    chk("ccs_seen", 128'h1, c);
    rdw(SEL_OCR, 4'h1, d, e);
    chk("ocr_word1_err", 128'h1, e);
    chk("ocr_word1_data", 128'h0, d);
    $display("test ocr done");
  endtask
  task automatic t_cid();
    logic [127:0] r, x;
    logic [31:0]  d;
    logic         e;
    x = {MAKER, APP, NAME, 8'h21, SERNO, 4'h0, 12'h16a, 7'h0, 1'h1};
    x[7:1] = crc7(x[127:8]);
    rd128(SEL_CID, r);
    chk("cid", x, r);
    rdw(SEL_DSR, 4'h0, d, e);
    chk("dsr_err", 128'h1, e);
    chk("dsr_data", 128'h0, d);
    rdw(sdreg_sel_t'(3'h7), 4'h0, d, e);
    chk("sel7_err", 128'h1, e);
    $display("test cid done");
  endtask
  task automatic t_csd();
    logic [127:0] r;
    speed_high = 1'h0;
    rd128(SEL_CSD, r);
    chk("csd_std", csd_exp(0, 0, 0, 0, 7'h0, 0), r);
    chk("erase_blk", 128'h1, r[46]);
    speed_high = 1'h1;
    rd128(SEL_CSD, r);
    chk("csd_hi", csd_exp(1, 0, 0, 0, 7'h0, 0), r);
    $display("test csd done");
  endtask
  task automatic t_prog();
    int           bits[5] = '{127, 100, 76, 46, 0};
    logic [127:0] r, img;
    logic         dn, er;
    img = csd_exp(1, 0, 0, 0, 7'h0, 0);
    foreach (bits[i]) begin
      host.prog(img ^ (128'h1 << bits[i]), dn, er);
      chk("ro_write_err", 128'h1, {dn, er});
    end
    host.prog(csd_exp(0, 0, 0, 0, 7'h0, 0), dn, er);
    chk("speed_write_err", 128'h1, {dn, er});
    rd128(SEL_CSD, r);
    chk("csd_unchanged", img, r);
    host.prog(csd_exp(1, 1, 0, 1, 7'h55, 1), dn, er);
    chk("prog_done", 128'h2, {dn, er});
    rd128(SEL_CSD, r);
    chk("csd_prog", csd_exp(1, 1, 0, 1, 7'h55, 1), r);
    host.prog(csd_exp(1, 1, 0, 0, 7'h2a, 1), dn, er);
    chk("tmp_rewrite", 128'h2, {dn, er});
    host.prog(csd_exp(1, 0, 0, 0, 7'h2a, 1), dn, er);
    chk("copy_relock", 128'h1, {dn, er});
    host.prog(csd_exp(1, 1, 1, 0, 7'h2a, 1), dn, er);
    chk("perm_relock", 128'h1, {dn, er});
    rd128(SEL_CSD, r);
    chk("csd_locked", csd_exp(1, 1, 0, 0, 7'h2a, 1), r);
    $display("test prog done");
  endtask
  task automatic t_rca();
    logic [15:0] addrs[5] = '{16'h1111, 16'h1234, 16'h5555, 16'h1234, 16'h0000};
    logic        sel_x[5] = '{1'h0, 1'h1, 1'h0, 1'h1, 1'h0};
    logic [31:0] d;
    logic        e;
    host.rca_write(16'h1234);
    chk("rca_out", 128'h1234, rca_q);
    rdw(SEL_RCA, 4'h0, d, e);
    chk("rca_read", 128'h1234, d);
    foreach (addrs[i]) begin
      host.select(addrs[i]);
      chk("card_selected", sel_x[i], card_sel);
    end
    $display("test rca done");
  endtask
  task automatic t_scr();
    logic [31:0] d;
    logic        e;
    rdw(SEL_SCR, 4'h0, d, e);
    chk("scr_w0", SCRV[31:0], d);
    rdw(SEL_SCR, 4'h1, d, e);
    chk("scr_w1", SCRV[63:32], d);
    rdw(SEL_SCR, 4'h2, d, e);
    chk("scr_w2_err", 128'h1, e);
    rdw(SEL_SSTAT, 4'h0, d, e);
    chk("stat_w0", 128'h13572468, d);
    rdw(SEL_SSTAT, 4'hf, d, e);
    chk("stat_w15", {1'h0, 32'hfeed0f0f}, {e, d});
    $display("test scr done");
  endtask
  task automatic t_reset();
    logic [127:0] r;
    host.select(16'h1234);
    chk("sel_before", 128'h1, card_sel);
    @(posedge clk_in);
    #1 rst_in = 1'h1;
    repeat (2) @(posedge clk_in);
    #1 rst_in = 1'h0;
    chk("rca_reset", 128'h0, rca_q);
    chk("sel_reset", 128'h0, card_sel);
    rd128(SEL_CSD, r);
    chk("csd_reset", csd_exp(1, 0, 0, 0, 7'h0, 0), r);
    $display("test reset done");
  endtask
  task automatic results();
    $display("checks %0d errors %0d", checks, num_errors);
    if (num_errors == 0 && checks > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask
  ////////////////////////////////////////
  initial begin
    rst_in = 1'h1;
    power_done = 1'h0;
    speed_high = 1'h0;
    repeat (8) @(posedge clk_in);
    #1 rst_in = 1'h0;
    host.power_up();
    t_ocr();
    t_cid();
    t_csd();
    t_prog();
    t_rca();
    t_reset();
    t_scr();
    results();
  end
  initial begin
    repeat (20000) @(posedge clk_in);
    num_errors++;
    results();
  end
endmodule
